// *** include/sbc_defines.svh ***
/*
  Constants of the operating-mode controller: timing, register map,
  field positions and bus answers.
  Assumes a 100 MHz clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define RESET_DELAY_A_NS 10000
`define RESET_DELAY_B_NS 20000
`define STRAP_FILTER_NS 200
`define RESET_DELAY_A_CYC ((`RESET_DELAY_A_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_DELAY_B_CYC ((`RESET_DELAY_B_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_FILTER_CYC ((`STRAP_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DELAY_W 12
`define FILT_W 5

// ----------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------
`define ADDR_W 8
`define ADDR_CTRL 8'h00
`define ADDR_STAT 8'h04
`define CTRL_MODE 1:0
`define CTRL_OV_RST 2
`define CTRL_AUX_EN 3
`define FRAME 15:0
`define MODE_CODE_NORMAL 2'h0
`define MODE_CODE_SLEEP 2'h1
`define MODE_CODE_STOP 2'h2
`define MODE_CODE_SOFT_RESET 2'h3
`define SEL_CTRL 2'h0
`define SEL_STAT 2'h1
`define SEL_NONE 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** include/sbc_pkg.sv ***
/*
  Types of the operating-mode controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sbc_pkg;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    MODE_INIT = 3'b000,
    MODE_NORMAL = 3'b001,
    MODE_STOP = 3'b010,
    MODE_SLEEP = 3'b011,
    MODE_RESTART = 3'b100,
    MODE_FAILSAFE = 3'b101
  } op_mode_t;

endpackage

// *** include/strap_if.sv ***
/*
  Carrier between the mode controller and the strap filter.
  Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none

interface strap_if;
  logic pin; // Raw strap level
  logic filter_on; // Filter runs while reset output is low
  logic filt_valid; // A stable value has been seen
  logic filt_value; // Last stable value

  modport ctrl (output pin, output filter_on, input filt_valid, input filt_value);
  modport filt (input pin, input filter_on, output filt_valid, output filt_value);
endinterface

`default_nettype wire

// *** src/strap_filter.sv ***
/*
  Filter on the configuration strap pin, running only while filter_on is high.
  Assumes the pin is synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defines.svh"

module strap_filter (
  input wire logic clk, // 100 MHz clock
  input wire logic resetn, // Synchronous reset, active low
  strap_if.filt strap // Pin in, filtered value out
);

  logic last_pin;
  logic [`FILT_W-1:0] stable_cnt;
  logic valid;
  logic value;
  logic next_last_pin;
  logic [`FILT_W-1:0] next_stable_cnt;
  logic next_valid;
  logic next_value;

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  // A level counts only after it stood for the whole filter time;
  // the last stable value survives glitchy periods
  always_comb
  begin
    next_last_pin = strap.pin;
    next_stable_cnt = stable_cnt;
    next_valid = valid;
    next_value = value;
    if (!strap.filter_on || strap.pin != last_pin)
    begin
      next_stable_cnt = '0;
    end
    else if (stable_cnt == `FILT_W'(`STRAP_FILTER_CYC - 1))
    begin
      next_valid = 1'b1;
      next_value = last_pin;
    end
    else
    begin
      next_stable_cnt = stable_cnt + `FILT_W'(1);
    end
  end

  // No filtered value yet means config 0
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      last_pin <= 1'b0;
      stable_cnt <= '0;
      valid <= 1'b0;
      value <= 1'b0;
    end
    else
    begin
      last_pin <= next_last_pin;
      stable_cnt <= next_stable_cnt;
      valid <= next_valid;
      value <= next_value;
    end
  end

  assign strap.filt_valid = valid;
  assign strap.filt_value = value;

endmodule

`default_nettype wire

// *** src/operating_mode_field_fsm.sv ***
/*
  Operating-mode state machine with its AXI4-Lite register slave.
  Assumes synchronous pins, one 100 MHz clock, and a watchdog, supplies
  and transceiver outside that obey the enables driven here.
*/
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defines.svh"

module operating_mode_field_fsm (
  input wire logic clk, // 100 MHz clock
  input wire logic resetn, // Power-on reset, active low
  input wire logic [`ADDR_W-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [`ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic wake_can, // Bus wake event
  input wire logic wake_input, // Wake pin event
  input wire logic sense_input, // Sense pin wake event
  input wire logic wake_gpio, // GPIO wake event
  input wire logic watchdog_fail, // Watchdog failure pulse
  input wire logic main_uv, // Main supply undervoltage
  input wire logic main_ov, // Main supply overvoltage
  input wire logic overtemp, // Overtemperature present
  input wire logic dev_select_pin, // Development-select level
  input wire logic config_strap_irq_pin, // Strap level
  output logic reset_out_n, // Controller reset, active low
  output logic strap_pulldown_en, // Weak pull-down on strap pin
  output logic main_supply_out, // Main supply enable
  output logic aux_supply_out, // Aux supply enable
  output logic low_power, // Reduced consumption request
  output logic can_force_normal, // Transceiver forced normal
  output logic watchdog_stop, // Watchdog counter frozen
  output logic wd_long_window_start, // Long open window start pulse
  output logic [2:0] op_mode // Current operating mode
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sbc_pkg::op_mode_t state, next_state;
  logic [`DELAY_W-1:0] delay_cnt, next_delay_cnt;
  logic next_reset_out_n, cfg_strap, next_cfg_strap, dev_mode, next_dev_mode;
  logic [1:0] mode_field, next_mode_field;
  logic ov_restart_en, next_ov_restart_en, aux_en, next_aux_en;
  logic wd_start, next_wd_start, ot_prev;
  logic aw_got, next_aw_got, w_got, next_w_got;
  logic [`ADDR_W-1:0] waddr_q, next_waddr_q;
  logic [31:0] wdata_q, next_wdata_q;
  logic wstrb0_q, next_wstrb0_q;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_do, wr_ctrl, wake_any, fail_now;
  sbc_pkg::op_mode_t fail_mode;
  strap_if strap ();

  // Address decode shared by both channels
  function automatic logic [1:0] addr_sel(input logic [`ADDR_W-1:0] a);
    if (a == `ADDR_CTRL)
      return `SEL_CTRL;
    else if (a == `ADDR_STAT)
      return `SEL_STAT;
    return `SEL_NONE;
  endfunction

  // Response to a watchdog or overvoltage fault follows the strap
  function automatic sbc_pkg::op_mode_t fault_target(input logic cfg);
    return cfg ? sbc_pkg::MODE_RESTART : sbc_pkg::MODE_FAILSAFE;
  endfunction

  strap_filter u_strap (
    .clk(clk),
    .resetn(resetn),
    .strap(strap.filt)
  );

  // Strap filter watches the pin only while reset output is low
  assign strap.pin = config_strap_irq_pin;
  assign strap.filter_on = !reset_out_n;
  assign strap_pulldown_en = !reset_out_n;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  // Address and data are taken in either order; the write acts once both are held
  assign awready = !aw_got;
  assign wready = !w_got;
  assign arready = !rvalid;
  assign wr_do = aw_got && w_got && !bvalid;
  assign wr_ctrl = wr_do && addr_sel(waddr_q) == `SEL_CTRL && wstrb0_q;

  always_comb
  begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_waddr_q = waddr_q;
    next_wdata_q = wdata_q;
    next_wstrb0_q = wstrb0_q;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !rready;
    next_rdata = rdata;
    next_rresp = rresp;
    if (awvalid && awready)
    begin
      next_aw_got = 1'b1;
      next_waddr_q = awaddr;
    end
    if (wvalid && wready)
    begin
      next_w_got = 1'b1;
      next_wdata_q = wdata;
      next_wstrb0_q = wstrb[0];
    end
    if (wr_do)
    begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = addr_sel(waddr_q) == `SEL_NONE ? `RESP_SLVERR : `RESP_OKAY;
    end
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = `RESP_OKAY;
      unique case (addr_sel(araddr))
        `SEL_CTRL: next_rdata = {28'h0000000, aux_en, ov_restart_en, mode_field};
        `SEL_STAT: next_rdata = {24'h000000, 1'b0, strap.filt_valid, reset_out_n,
                                 dev_mode, cfg_strap, state};
        default:
        begin
          next_rdata = 32'h00000000;
          next_rresp = `RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb0_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end
    else
    begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      waddr_q <= next_waddr_q;
      wdata_q <= next_wdata_q;
      wstrb0_q <= next_wstrb0_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // Mode machine
  // ----------------------------------------------------------------
  assign wake_any = wake_can || wake_input || sense_input || wake_gpio;
  // Frozen watchdog cannot fail, so development mode never sees it
  assign fail_now = (watchdog_fail && !dev_mode) || main_uv || overtemp
                    || (main_ov && ov_restart_en);
  always_comb
  begin
    if (overtemp)
      fail_mode = sbc_pkg::MODE_FAILSAFE;
    else if (main_uv)
      fail_mode = sbc_pkg::MODE_RESTART;
    else
      fail_mode = fault_target(cfg_strap);
  end

  always_comb
  begin
    next_state = state;
    next_delay_cnt = delay_cnt == '0 ? delay_cnt : delay_cnt - `DELAY_W'(1);
    next_reset_out_n = reset_out_n;
    next_cfg_strap = cfg_strap;
    next_dev_mode = dev_mode;
    next_mode_field = mode_field;
    next_ov_restart_en = ov_restart_en;
    next_aux_en = aux_en;
    next_wd_start = 1'b0;
    unique case (state)
      sbc_pkg::MODE_INIT:
      begin
        // Wake events are ignored here
        if (!reset_out_n)
        begin
          if (delay_cnt == '0)
          begin
            next_reset_out_n = 1'b1;
            next_wd_start = 1'b1;
            next_cfg_strap = strap.filt_valid && strap.filt_value;
            next_dev_mode = dev_select_pin;
          end
        end
        else if (fail_now)
          next_state = sbc_pkg::MODE_RESTART;
        else if (wr_do)
          next_state = sbc_pkg::MODE_NORMAL;
      end
      sbc_pkg::MODE_NORMAL, sbc_pkg::MODE_STOP:
      begin
        if (fail_now)
          next_state = fail_mode;
        else if (wr_ctrl)
        begin
          next_mode_field = wdata_q[`CTRL_MODE];
          next_ov_restart_en = wdata_q[`CTRL_OV_RST];
          next_aux_en = wdata_q[`CTRL_AUX_EN];
          unique case (wdata_q[`CTRL_MODE])
            `MODE_CODE_NORMAL: next_state = sbc_pkg::MODE_NORMAL;
            `MODE_CODE_SLEEP: next_state = sbc_pkg::MODE_SLEEP;
            `MODE_CODE_STOP: next_state = sbc_pkg::MODE_STOP;
            `MODE_CODE_SOFT_RESET:
            begin
              // No lock bits exist, so every field takes its soft-reset value
              next_state = sbc_pkg::MODE_INIT;
              next_mode_field = `MODE_CODE_NORMAL;
              next_ov_restart_en = 1'b0;
              next_aux_en = 1'b0;
            end
          endcase
        end
      end
      sbc_pkg::MODE_SLEEP:
      begin
        if (wake_any)
          next_state = sbc_pkg::MODE_RESTART;
      end
      sbc_pkg::MODE_RESTART:
      begin
        if (delay_cnt == '0 && !main_uv)
        begin
          next_state = sbc_pkg::MODE_NORMAL;
          next_reset_out_n = 1'b1;
          next_wd_start = 1'b1;
          next_cfg_strap = strap.filt_valid && strap.filt_value;
        end
      end
      sbc_pkg::MODE_FAILSAFE:
      begin
        if (wake_any || (ot_prev && !overtemp))
          next_state = sbc_pkg::MODE_RESTART;
      end
      default:
        next_state = sbc_pkg::MODE_INIT;
    endcase
    // Restart entry: reset low, delay loaded, field cleared
    if (next_state == sbc_pkg::MODE_RESTART && state != sbc_pkg::MODE_RESTART)
    begin
      next_reset_out_n = 1'b0;
      next_mode_field = `MODE_CODE_NORMAL;
      next_delay_cnt = (state == sbc_pkg::MODE_SLEEP || state == sbc_pkg::MODE_FAILSAFE)
                       ? `DELAY_W'(`RESET_DELAY_B_CYC) : `DELAY_W'(`RESET_DELAY_A_CYC);
    end
    // Fail-safe keeps the controller in reset since its supply is gone
    if (next_state == sbc_pkg::MODE_FAILSAFE || next_state == sbc_pkg::MODE_SLEEP)
      next_reset_out_n = 1'b0;
  end

  // Power-on reset forces init with the first reset delay running
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state <= sbc_pkg::MODE_INIT;
      delay_cnt <= `DELAY_W'(`RESET_DELAY_A_CYC);
      reset_out_n <= 1'b0;
      cfg_strap <= 1'b0;
      dev_mode <= 1'b0;
      mode_field <= `MODE_CODE_NORMAL;
      ov_restart_en <= 1'b0;
      aux_en <= 1'b0;
      wd_start <= 1'b0;
      ot_prev <= 1'b0;
    end
    else
    begin
      state <= next_state;
      delay_cnt <= next_delay_cnt;
      reset_out_n <= next_reset_out_n;
      cfg_strap <= next_cfg_strap;
      dev_mode <= next_dev_mode;
      mode_field <= next_mode_field;
      ov_restart_en <= next_ov_restart_en;
      aux_en <= next_aux_en;
      wd_start <= next_wd_start;
      ot_prev <= overtemp;
    end
  end

  // ----------------------------------------------------------------
  // Mode outputs
  // ----------------------------------------------------------------
  // Decoded from the state register, dev_mode, aux_en and wd_start
  assign main_supply_out = state != sbc_pkg::MODE_SLEEP
                           && state != sbc_pkg::MODE_FAILSAFE;
  assign low_power = state == sbc_pkg::MODE_STOP;
  assign aux_supply_out = dev_mode || (aux_en && main_supply_out);
  assign can_force_normal = dev_mode;
  assign watchdog_stop = dev_mode;
  assign wd_long_window_start = wd_start;
  assign op_mode = state;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_restart_holds_reset: assert property (
    state == sbc_pkg::MODE_RESTART |-> !reset_out_n)
    else $error("Reset output high during restart");
  chk_stop_supply_on: assert property (
    state == sbc_pkg::MODE_STOP |-> main_supply_out && low_power)
    else $error("Stop mode lost main supply");
  chk_sleep_supply_off: assert property (
    state == sbc_pkg::MODE_SLEEP |-> !main_supply_out)
    else $error("Main supply on in sleep");
  chk_failsafe_supply_off: assert property (
    state != sbc_pkg::MODE_INIT && overtemp |=> state == sbc_pkg::MODE_FAILSAFE
      && !main_supply_out)
    else $error("Overtemperature did not reach fail-safe");
  chk_failsafe_wake_exit: assert property (
    state == sbc_pkg::MODE_FAILSAFE && wake_any |=> state == sbc_pkg::MODE_RESTART)
    else $error("Wake did not leave fail-safe");
  chk_restart_field_clear: assert property (
    $rose(state == sbc_pkg::MODE_RESTART) |-> mode_field == `MODE_CODE_NORMAL
      && delay_cnt != '0)
    else $error("Mode field not cleared in restart");
  chk_restart_exit_normal: assert property (
    state == sbc_pkg::MODE_RESTART && delay_cnt == '0 && !main_uv
      |=> state == sbc_pkg::MODE_NORMAL && reset_out_n && wd_long_window_start)
    else $error("Restart did not end into normal");
  chk_init_any_frame: assert property (
    state == sbc_pkg::MODE_INIT && reset_out_n && wr_do && !fail_now
      |=> state == sbc_pkg::MODE_NORMAL)
    else $error("Command in init did not reach normal");
  chk_wd_after_release: assert property (
    wd_long_window_start |-> reset_out_n && !$past(reset_out_n))
    else $error("Watchdog window started before reset release");
  chk_dev_mode_outputs: assert property (
    dev_mode |-> watchdog_stop && can_force_normal && aux_supply_out)
    else $error("Development mode outputs wrong");
  chk_strap_default: assert property (
    $rose(reset_out_n) && !$past(strap.filt_valid) |-> !cfg_strap)
    else $error("Strap default not fail-safe");

  cov_stop_entry: cover property (state == sbc_pkg::MODE_NORMAL
    ##1 state == sbc_pkg::MODE_STOP);
  cov_sleep_wake: cover property (state == sbc_pkg::MODE_SLEEP
    ##1 state == sbc_pkg::MODE_RESTART);
  cov_failsafe: cover property (state == sbc_pkg::MODE_FAILSAFE);
  cov_soft_reset: cover property (state == sbc_pkg::MODE_NORMAL
    ##1 state == sbc_pkg::MODE_INIT);

endmodule

`default_nettype wire

// *** verification/host_model.sv ***
/*
  Host controller model: an AXI4-Lite master that sends each command frame
  as one word write and reads status words.
  Assumes a slave on the same clock that answers whenever it likes.
*/
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input wire logic clk, // Bus clock
  output logic [7:0] awaddr, // Write address
  output logic awvalid, // Write address valid
  input wire logic awready, // Write address ready
  output logic [31:0] wdata, // Write data
  output logic [3:0] wstrb, // Write strobes
  output logic wvalid, // Write data valid
  input wire logic wready, // Write data ready
  input wire logic [1:0] bresp, // Write response
  input wire logic bvalid, // Write response valid
  output logic bready, // Write response ready
  output logic [7:0] araddr, // Read address
  output logic arvalid, // Read address valid
  input wire logic arready, // Read address ready
  input wire logic [31:0] rdata, // Read data
  input wire logic [1:0] rresp, // Read response
  input wire logic rvalid, // Read data valid
  output logic rready // Read data ready
);
  // Bus idle from time zero
  initial
  begin
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
  end

  // Handshakes are read at the falling edge, so each rising edge acts on settled values
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta;
    logic tw;
    logic tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'b111;
    do
    begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
    end
    while (!tb);
    bready <= 1'b0;
  endtask

  // Address is held until taken, rready until the data shows
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta;
    logic tr;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do
    begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta)
        arvalid <= 1'b0;
    end
    while (!tr);
    rready <= 1'b0;
  endtask
endmodule

`default_nettype wire

// *** verification/sbc_operating_mode_fsm_bench.sv ***
/*
  Self-checking bench of the operating-mode controller.
  Assumes the design's own assertions and the host model beside it.
*/
`timescale 1ns/1ps
`default_nettype none

module sbc_operating_mode_fsm_bench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] ev = 8'h00; // can, pin, sense, gpio, wd, uv, ov, temp
  logic dev_sel = 1'b0;
  logic strap = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic rst_o_n, mso, aux, lp, cfn, wds, pde;
  logic [2:0] op_mode;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  host_model host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  operating_mode_field_fsm DUT (.clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wake_can(ev[7]), .wake_input(ev[6]), .sense_input(ev[5]), .wake_gpio(ev[4]),
    .watchdog_fail(ev[3]), .main_uv(ev[2]), .main_ov(ev[1]), .overtemp(ev[0]),
    .dev_select_pin(dev_sel), .config_strap_irq_pin(strap), .reset_out_n(rst_o_n),
    .strap_pulldown_en(pde), .main_supply_out(mso), .aux_supply_out(aux), .low_power(lp),
    .can_force_normal(cfn), .watchdog_stop(wds), .wd_long_window_start(), .op_mode(op_mode));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for a mode, then compare it
  task automatic wm(input logic [2:0] m, input int lim);
    for (int i = 0; i < lim && op_mode !== m; i++)
      @(negedge clk);
    chk({29'h0, op_mode}, {29'h0, m});
  endtask

  task automatic put(input logic [31:0] d);
    host.wr(8'h00, d, rs);
    chk({30'h0, rs}, 32'h0);
  endtask

  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
  endtask

  // Reset output release can take the whole first reset delay
  task automatic wait_release();
    for (int i = 0; i < 1100 && rst_o_n !== 1'b1; i++)
      @(negedge clk);
    @(negedge clk);
  endtask

  // A hung handshake must not stall the run
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 60000)
    begin
      err_total = err_total + 1;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    wm(sbc_pkg::MODE_INIT, 1);
    chk({30'h0, pde, rst_o_n}, 32'h2);
    wait_release();
    wm(sbc_pkg::MODE_INIT, 1);
    chk({30'h0, pde, rst_o_n}, 32'h1);
    put(32'h0);
    wm(sbc_pkg::MODE_NORMAL, 1);
    host.rd(8'h04, rv, rs);
    chk({25'h0, rv[6:0]}, 32'h61);
    host.rd(8'h08, rv, rs);
    chk({rv[29:0], rs}, 32'h2);
    put(32'hA);
    chk({29'h0, mso, lp, aux}, 32'h7);
    for (int b = 7; b >= 4; b--)
    begin
      put(32'h1);
      chk({31'h0, mso}, 32'h0);
      pulse(b);
      wm(sbc_pkg::MODE_RESTART, 4);
      chk({31'h0, rst_o_n}, 32'h0);
      host.rd(8'h00, rv, rs);
      chk({30'h0, rv[1:0]}, 32'h0);
      wm(sbc_pkg::MODE_NORMAL, 2100);
      pulse(3);
      wm(sbc_pkg::MODE_FAILSAFE, 4);
      chk({31'h0, mso}, 32'h0);
      pulse(b);
      wm(sbc_pkg::MODE_RESTART, 4);
      repeat (1990) @(negedge clk);
      wm(sbc_pkg::MODE_RESTART, 1);
      wm(sbc_pkg::MODE_NORMAL, 20);
    end
    @(posedge clk);
    ev[0] <= 1'b1;
    wm(sbc_pkg::MODE_FAILSAFE, 4);
    @(posedge clk);
    ev[0] <= 1'b0;
    wm(sbc_pkg::MODE_RESTART, 4);
    wm(sbc_pkg::MODE_NORMAL, 2100);
    pulse(2);
    wm(sbc_pkg::MODE_RESTART, 4);
    repeat (990) @(negedge clk);
    wm(sbc_pkg::MODE_RESTART, 1);
    wm(sbc_pkg::MODE_NORMAL, 20);
    put(32'h4);
    pulse(1);
    wm(sbc_pkg::MODE_FAILSAFE, 4);
    pulse(6);
    wm(sbc_pkg::MODE_NORMAL, 2100);
    put(32'h3);
    wm(sbc_pkg::MODE_INIT, 1);
    put(32'h0);
    wm(sbc_pkg::MODE_NORMAL, 1);
    // Second power-up with both straps high
    @(posedge clk);
    {resetn, dev_sel, strap} <= 3'b011;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    wait_release();
    chk({29'h0, wds, cfn, aux}, 32'h7);
    host.rd(8'h04, rv, rs);
    chk({30'h0, rv[4:3]}, 32'h3);
    put(32'h0);
    put(32'h4);
    pulse(3);
    repeat (3) @(negedge clk);
    wm(sbc_pkg::MODE_NORMAL, 1);
    pulse(1);
    wm(sbc_pkg::MODE_RESTART, 4);
    conclude();
  end
endmodule

`default_nettype wire
